// ===== inc/ads_pkg.sv
// Purpose: shared constants of the converter delay sequencer
// Assumes: 125 MHz system clock, delay ticks near the 16 MHz converter rate
// Notes:   register offsets are byte addresses of 32-bit words
package ads_pkg;
  // ************************************************************
  // timing
  // ************************************************************
  localparam int unsigned CLK_HZ          = 125_000_000;
  localparam int unsigned CLK_PERIOD_PS   = 8_000;
  localparam int unsigned CONV_CLK_HZ     = 16_000_000;
  // tick divider rounds up, so a tick never comes faster than 16 MHz
  localparam int unsigned TICK_DIV        = (CLK_HZ + CONV_CLK_HZ - 1) / CONV_CLK_HZ;
  localparam int unsigned TICK_W          = $clog2(TICK_DIV);
  localparam int unsigned MAX_DELAY_US    = 32;
  localparam int unsigned MAX_DELAY_TICKS = MAX_DELAY_US * (CONV_CLK_HZ / 1_000_000);
  localparam int unsigned DLY_W           = $clog2(MAX_DELAY_TICKS);
  localparam int unsigned CONV_TIME_PS    = 62_500;
  localparam int unsigned CONV_CYC        = (CONV_TIME_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned CV_W            = $clog2(CONV_CYC);
  localparam int unsigned SETTLE_TIME_NS  = 1_000;
  localparam int unsigned SETTLE_CYC      = (SETTLE_TIME_NS * 1_000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned SETTLE_W        = $clog2(SETTLE_CYC + 1);
  // ************************************************************
  // register map
  // ************************************************************
  localparam int unsigned ADDR_W   = 8;
  localparam int unsigned DATA_W   = 32;
  localparam int unsigned CH_W     = 3;
  localparam int unsigned RES_W    = 10;
  localparam logic [7:0]  OFF_MAIN = 8'h00;
  localparam logic [7:0]  OFF_AUX  = 8'h04;
  localparam logic [7:0]  OFF_DLY1 = 8'h08;
  localparam logic [7:0]  OFF_DLY2 = 8'h0C;
  localparam logic [7:0]  OFF_STAT = 8'h10;
  localparam logic [7:0]  OFF_RES  = 8'h14;
  // converter_main_control fields
  localparam int unsigned MAIN_EN_BIT    = 0;
  localparam int unsigned MAIN_START_BIT = 1;
  localparam int unsigned MAIN_LDO_BIT   = 2;
  localparam int unsigned MAIN_MID_BIT   = 3;
  localparam int unsigned MAIN_CH_LSB    = 4;
  // converter_aux_control fields
  localparam int unsigned AUX_DEN_BIT    = 0;
  localparam int unsigned AUX_ATTN_BIT   = 1;
  // delay setting fields
  localparam int unsigned DLY1_LDO_LSB   = 0;
  localparam int unsigned DLY1_EN_LSB    = 16;
  localparam int unsigned DLY2_ST_LSB    = 0;
  // status fields
  localparam int unsigned ST_BUSY_BIT    = 0;
  localparam int unsigned ST_DONE_BIT    = 1;
  localparam int unsigned ST_SETTLED_BIT = 2;
  localparam int unsigned ST_ACTIVE_BIT  = 3;
  localparam int unsigned ST_HALTED_BIT  = 4;
  localparam int unsigned ST_ATTN_BIT    = 5;
  localparam int unsigned ST_CNT_LSB     = 16;
  // reset values: regulator first, converter enable at 4 us, start at 8 us
  localparam logic [DLY_W-1:0] RST_DLY_LDO = 9'h000;
  localparam logic [DLY_W-1:0] RST_DLY_EN  = 9'h040;
  localparam logic [DLY_W-1:0] RST_DLY_ST  = 9'h080;
  // conversion phase
  typedef enum logic {
    ADS_CV_IDLE    = 1'b0,
    ADS_CV_CONVERT = 1'b1
  } ads_cv_state_t;
endpackage

// ===== inc/ads_dly_if.sv
// Purpose: link between sequencer control and its delay counter
// Assumes: single clock domain
// Notes:   clear is a level, start and stop are one-cycle pulses
`timescale 1ns/1ps
interface ads_dly_if;
  logic                     clear;
  logic                     start;
  logic                     stop;
  logic                     active;
  logic                     halted;
  logic [ads_pkg::DLY_W-1:0] count;
  modport ctrl (output clear, output start, output stop, input active, input halted, input count);
  modport cnt  (input clear, input start, input stop, output active, output halted, output count);
endinterface

// ===== hdl/ads_delay_cnt.sv
// Purpose: delay counter stepping at the converter clock rate
// Assumes: clear held high resets everything
// Notes:   once halted, a new start is ignored until cleared
`timescale 1ns/1ps
module ads_delay_cnt (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // control link
  ads_dly_if.cnt   dly
);
  logic [ads_pkg::TICK_W-1:0] div_q;
  logic                       active_q;
  logic                       halted_q;
  logic [ads_pkg::DLY_W-1:0]  count_q;
  logic                       tick;
  logic                       go;

  assign go         = dly.start && !active_q && !halted_q;
  assign tick       = active_q && (div_q == ads_pkg::TICK_W'(ads_pkg::TICK_DIV - 1));
  assign dly.active = active_q;
  assign dly.halted = halted_q;
  assign dly.count  = count_q;

  // ************************************************************
  // tick divider
  // ************************************************************
  // one tick per converter clock period
  always_ff @(posedge clk) begin
    if (rst || !active_q || tick) begin
      div_q <= '0;
    end else begin
      div_q <= div_q + 1'b1;
    end
  end

  // run and halt state
  always_ff @(posedge clk) begin
    if (rst || dly.clear) begin
      active_q <= 1'b0;
      halted_q <= 1'b0;
    end else if (dly.stop && active_q) begin
      active_q <= 1'b0;
      halted_q <= 1'b1;
    end else if (go) begin
      active_q <= 1'b1;
    end
  end

  // count saturates at the top so the longest delay stays reached
  always_ff @(posedge clk) begin
    if (rst || dly.clear || go) begin
      count_q <= '0;
    end else if (tick && (count_q != '1)) begin
      count_q <= count_q + 1'b1;
    end
  end

  a_halt_hold: assert property (@(posedge clk) disable iff (rst)
    halted_q && !dly.clear |=> $stable(count_q)) else $error("halted count moved");
  a_tick_spacing: assert property (@(posedge clk) disable iff (rst)
    tick |=> !tick [*7]) else $error("ticks too close");
endmodule

// ===== hdl/ads_delay_sequencer.sv
// Purpose: control sequencer of the general purpose converter
// Assumes: one 125 MHz clock, plain register port, analog core on same clock
// Notes:   staggers regulator, enable and start through a delay counter
`timescale 1ns/1ps
module ads_delay_sequencer #(
  parameter logic [ads_pkg::CH_W-1:0] BATT_CH = 3'h7
) (
  // clock and reset
  input  wire logic                        clk,
  input  wire logic                        rst,
  // register port
  input  wire logic [ads_pkg::ADDR_W-1:0]  reg_addr,
  input  wire logic [ads_pkg::DATA_W-1:0]  reg_wdata,
  input  wire logic                        reg_we,
  input  wire logic                        reg_re,
  output      logic [ads_pkg::DATA_W-1:0]  reg_rdata,
  // analog core
  output      logic                        regulator_en,
  output      logic                        converter_en,
  output      logic                        conversion_start,
  output      logic                        attenuator_on,
  output      logic                        midscale_on,
  output      logic [ads_pkg::CH_W-1:0]    channel_sel,
  input  wire logic [ads_pkg::RES_W-1:0]   core_result
);
  ads_dly_if dly ();

  logic                          regulator_enable_bit_q;
  logic                          converter_enable_bit_q;
  logic                          conversion_start_bit_q;
  logic                          input_midscale_select_q;
  logic [ads_pkg::CH_W-1:0]      chan_q;
  logic                          delay_counter_enable_q;
  logic                          triple_attenuator_enable_q;
  logic [ads_pkg::DLY_W-1:0]     dly_ldo_q;
  logic [ads_pkg::DLY_W-1:0]     dly_en_q;
  logic [ads_pkg::DLY_W-1:0]     dly_st_q;
  logic                          done_q;
  logic [ads_pkg::RES_W-1:0]     result_q;
  logic [ads_pkg::DATA_W-1:0]    rdata_q;
  logic [ads_pkg::SETTLE_W-1:0]  settle_q;
  logic [ads_pkg::CH_W:0]        key_q;
  logic [ads_pkg::CV_W-1:0]      timer_q;
  ads_pkg::ads_cv_state_t        state_q;
  logic                          regulator_en_q;
  logic                          converter_en_q;
  logic                          conversion_start_q;
  logic                          attenuator_on_q;
  logic                          midscale_on_q;
  logic                          wr_main;
  logic                          wr_aux;
  logic                          wr_stat;
  logic                          started;
  logic                          start_gate;
  logic                          attn_eff;
  logic                          finish;
  logic                          settled;

  // ************************************************************
  // helpers
  // ************************************************************
  // bit passes straight through unless the counter enable asks for a delay
  function automatic logic gate_sig(input logic bit_v, input logic den, input logic run,
                                    input logic [ads_pkg::DLY_W-1:0] cnt,
                                    input logic [ads_pkg::DLY_W-1:0] setting);
    return bit_v & (~den | (run & (cnt >= setting)));
  endfunction

  assign wr_main    = reg_we && (reg_addr == ads_pkg::OFF_MAIN);
  assign wr_aux     = reg_we && (reg_addr == ads_pkg::OFF_AUX);
  assign wr_stat    = reg_we && (reg_addr == ads_pkg::OFF_STAT);
  // a halted counter keeps its count, so the regulator and converter enables it released stay on
  assign started    = dly.active | dly.halted;
  assign start_gate = gate_sig(conversion_start_bit_q, delay_counter_enable_q, started,
                               dly.count, dly_st_q);
  assign attn_eff   = triple_attenuator_enable_q | (chan_q == BATT_CH);
  assign finish     = (state_q == ads_pkg::ADS_CV_CONVERT) && (timer_q == '0);
  assign settled    = (settle_q == ads_pkg::SETTLE_W'(ads_pkg::SETTLE_CYC));

  // counter control
  assign dly.clear  = !delay_counter_enable_q;
  assign dly.start  = wr_main && reg_wdata[ads_pkg::MAIN_START_BIT] && delay_counter_enable_q;
  assign dly.stop   = finish;

  ads_delay_cnt u_cnt (
    .clk (clk),
    .rst (rst),
    .dly (dly)
  );

  // ************************************************************
  // registers
  // ************************************************************
  // main control; a software write of start wins over the finish clear
  always_ff @(posedge clk) begin
    if (rst) begin
      regulator_enable_bit_q  <= 1'b0;
      converter_enable_bit_q  <= 1'b0;
      conversion_start_bit_q  <= 1'b0;
      input_midscale_select_q <= 1'b0;
      chan_q                  <= '0;
    end else if (wr_main) begin
      regulator_enable_bit_q  <= reg_wdata[ads_pkg::MAIN_LDO_BIT];
      converter_enable_bit_q  <= reg_wdata[ads_pkg::MAIN_EN_BIT];
      conversion_start_bit_q  <= reg_wdata[ads_pkg::MAIN_START_BIT];
      input_midscale_select_q <= reg_wdata[ads_pkg::MAIN_MID_BIT];
      chan_q                  <= reg_wdata[ads_pkg::MAIN_CH_LSB +: ads_pkg::CH_W];
    end else if (finish) begin
      conversion_start_bit_q  <= 1'b0;
    end
  end

  // aux control
  always_ff @(posedge clk) begin
    if (rst) begin
      delay_counter_enable_q     <= 1'b0;
      triple_attenuator_enable_q <= 1'b0;
    end else if (wr_aux) begin
      delay_counter_enable_q     <= reg_wdata[ads_pkg::AUX_DEN_BIT];
      triple_attenuator_enable_q <= reg_wdata[ads_pkg::AUX_ATTN_BIT];
    end
  end

  // delay settings
  always_ff @(posedge clk) begin
    if (rst) begin
      dly_ldo_q <= ads_pkg::RST_DLY_LDO;
      dly_en_q  <= ads_pkg::RST_DLY_EN;
      dly_st_q  <= ads_pkg::RST_DLY_ST;
    end else begin
      if (reg_we && (reg_addr == ads_pkg::OFF_DLY1)) begin
        dly_ldo_q <= reg_wdata[ads_pkg::DLY1_LDO_LSB +: ads_pkg::DLY_W];
        dly_en_q  <= reg_wdata[ads_pkg::DLY1_EN_LSB +: ads_pkg::DLY_W];
      end
      if (reg_we && (reg_addr == ads_pkg::OFF_DLY2)) begin
        dly_st_q  <= reg_wdata[ads_pkg::DLY2_ST_LSB +: ads_pkg::DLY_W];
      end
    end
  end

  // ************************************************************
  // conversion phase
  // ************************************************************
  // fixed length phase; the attenuator only stretches sampling, not this
  always_ff @(posedge clk) begin
    if (rst) begin
      state_q <= ads_pkg::ADS_CV_IDLE;
      timer_q <= '0;
    end else begin
      unique case (state_q)
        ads_pkg::ADS_CV_IDLE: begin
          if (start_gate) begin
            state_q <= ads_pkg::ADS_CV_CONVERT;
            timer_q <= ads_pkg::CV_W'(ads_pkg::CONV_CYC - 1);
          end
        end
        ads_pkg::ADS_CV_CONVERT: begin
          if (timer_q == '0) begin
            state_q <= ads_pkg::ADS_CV_IDLE;
          end else begin
            timer_q <= timer_q - 1'b1;
          end
        end
      endcase
    end
  end

  // result capture and sticky done; the finish set wins over a clear
  always_ff @(posedge clk) begin
    if (rst) begin
      done_q   <= 1'b0;
      result_q <= '0;
    end else if (finish) begin
      done_q   <= 1'b1;
      result_q <= core_result;
    end else if (wr_stat && reg_wdata[ads_pkg::ST_DONE_BIT]) begin
      done_q   <= 1'b0;
    end
  end

  // settling timer restarts whenever channel or attenuator changes
  always_ff @(posedge clk) begin
    if (rst) begin
      key_q    <= '0;
      settle_q <= '0;
    end else begin
      key_q <= {chan_q, attn_eff};
      if (key_q != {chan_q, attn_eff}) begin
        settle_q <= '0;
      end else if (!settled) begin
        settle_q <= settle_q + 1'b1;
      end
    end
  end

  // ************************************************************
  // analog outputs
  // ************************************************************
  always_ff @(posedge clk) begin
    if (rst) begin
      regulator_en_q     <= 1'b0;
      converter_en_q     <= 1'b0;
      conversion_start_q <= 1'b0;
      attenuator_on_q    <= 1'b0;
      midscale_on_q      <= 1'b0;
    end else begin
      regulator_en_q     <= gate_sig(regulator_enable_bit_q, delay_counter_enable_q, started,
                                     dly.count, dly_ldo_q);
      converter_en_q     <= gate_sig(converter_enable_bit_q, delay_counter_enable_q, started,
                                     dly.count, dly_en_q);
      conversion_start_q <= start_gate;
      attenuator_on_q    <= attn_eff;
      midscale_on_q      <= input_midscale_select_q;
    end
  end

  assign regulator_en     = regulator_en_q;
  assign converter_en     = converter_en_q;
  assign conversion_start = conversion_start_q;
  assign attenuator_on    = attenuator_on_q;
  assign midscale_on      = midscale_on_q;
  assign channel_sel      = chan_q;

  // ************************************************************
  // read back
  // ************************************************************
  // data stands only in the cycle after the read; unmapped reads give zero
  always_ff @(posedge clk) begin
    if (rst || !reg_re) begin
      rdata_q <= '0;
    end else begin
      rdata_q <= '0;
      case (reg_addr)
        ads_pkg::OFF_MAIN: begin
          rdata_q[ads_pkg::MAIN_EN_BIT]                    <= converter_enable_bit_q;
          rdata_q[ads_pkg::MAIN_START_BIT]                 <= conversion_start_bit_q;
          rdata_q[ads_pkg::MAIN_LDO_BIT]                   <= regulator_enable_bit_q;
          rdata_q[ads_pkg::MAIN_MID_BIT]                   <= input_midscale_select_q;
          rdata_q[ads_pkg::MAIN_CH_LSB +: ads_pkg::CH_W]   <= chan_q;
        end
        ads_pkg::OFF_AUX: begin
          rdata_q[ads_pkg::AUX_DEN_BIT]                    <= delay_counter_enable_q;
          rdata_q[ads_pkg::AUX_ATTN_BIT]                   <= triple_attenuator_enable_q;
        end
        ads_pkg::OFF_DLY1: begin
          rdata_q[ads_pkg::DLY1_LDO_LSB +: ads_pkg::DLY_W] <= dly_ldo_q;
          rdata_q[ads_pkg::DLY1_EN_LSB +: ads_pkg::DLY_W]  <= dly_en_q;
        end
        ads_pkg::OFF_DLY2: rdata_q[ads_pkg::DLY2_ST_LSB +: ads_pkg::DLY_W] <= dly_st_q;
        ads_pkg::OFF_STAT: begin
          rdata_q[ads_pkg::ST_BUSY_BIT]                    <= (state_q == ads_pkg::ADS_CV_CONVERT);
          rdata_q[ads_pkg::ST_DONE_BIT]                    <= done_q;
          rdata_q[ads_pkg::ST_SETTLED_BIT]                 <= settled;
          rdata_q[ads_pkg::ST_ACTIVE_BIT]                  <= dly.active;
          rdata_q[ads_pkg::ST_HALTED_BIT]                  <= dly.halted;
          rdata_q[ads_pkg::ST_ATTN_BIT]                    <= attn_eff;
          rdata_q[ads_pkg::ST_CNT_LSB +: ads_pkg::DLY_W]   <= dly.count;
        end
        ads_pkg::OFF_RES: rdata_q[ads_pkg::RES_W-1:0] <= result_q;
        default: rdata_q <= '0;
      endcase
    end
  end

  assign reg_rdata = rdata_q;

  // ************************************************************
  // checks
  // ************************************************************
  a_counter_start: assert property (@(posedge clk) disable iff (rst)
    dly.start && !dly.active && !dly.halted |=> dly.active && (dly.count == '0))
    else $error("counter did not start");
  a_counter_clear: assert property (@(posedge clk) disable iff (rst)
    !delay_counter_enable_q |=> (dly.count == '0) && !dly.active && !dly.halted)
    else $error("counter not cleared");
  a_bypass_follow: assert property (@(posedge clk) disable iff (rst)
    !delay_counter_enable_q |=> regulator_en == $past(regulator_enable_bit_q))
    else $error("regulator enable not following its bit");
  a_delay_holds: assert property (@(posedge clk) disable iff (rst)
    delay_counter_enable_q && !started |=> !converter_en && !conversion_start)
    else $error("signal released before counter start");
  a_reset_stagger: assert property (@(posedge clk)
    $past(rst) && !rst |-> (dly_ldo_q < dly_en_q) && (dly_en_q < dly_st_q))
    else $error("reset delays not staggered");
  a_conv_length: assert property (@(posedge clk) disable iff (rst)
    $rose(state_q == ads_pkg::ADS_CV_CONVERT) |-> (state_q == ads_pkg::ADS_CV_CONVERT) [*8]
    ##1 (state_q == ads_pkg::ADS_CV_IDLE))
    else $error("conversion phase length wrong");
  a_finish_stop: assert property (@(posedge clk) disable iff (rst)
    finish && dly.active && delay_counter_enable_q |=> dly.halted && !dly.active)
    else $error("counter not stopped at finish");
  a_batt_attn: assert property (@(posedge clk) disable iff (rst)
    chan_q == BATT_CH |=> attenuator_on)
    else $error("battery channel without attenuator");
  a_midscale_path: assert property (@(posedge clk) disable iff (rst)
    input_midscale_select_q |=> midscale_on)
    else $error("mid-scale not applied");
  a_settle_restart: assert property (@(posedge clk) disable iff (rst)
    $changed(chan_q) |=> !settled [*2])
    else $error("settle flag not restarted");
endmodule

// ===== test/ads_core_model.sv
// Purpose: behavioural analog core facing the converter sequencer
// Assumes: the core converts only while regulator and converter are both on
// Notes:   an unpowered core toggles its result, so a stale value never passes
`timescale 1ns/1ps
module ads_core_model (
  // clock
  input  wire logic       clk,
  // controls from the sequencer
  input  wire logic       regulator_en,
  input  wire logic       converter_en,
  input  wire logic       midscale_on,
  // analog level chosen by the bench
  input  wire logic [9:0] level,
  // result towards the sequencer
  output      logic [9:0] core_result
);
  logic [9:0] res_q = 10'h155;
  assign core_result = res_q;
  // powered core converts the level, or centre scale when muted
  always @(posedge clk) begin
    if (regulator_en && converter_en) begin
      res_q <= midscale_on ? 10'h200 : level;
    end else begin
      res_q <= ~res_q;
    end
  end
endmodule

// ===== test/tb_top.sv
// Purpose: self-checking bench of the converter delay sequencer
// Assumes: default battery channel 7, fixed seed
// Notes:   rise times are sampled on the falling edge, away from updates
`timescale 1ns/1ps
module tb_top;
  localparam logic [2:0] BATT = 3'h7;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [7:0]  reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0000_0000;
  logic        reg_we = 1'b0;
  logic        reg_re = 1'b0;
  logic [31:0] reg_rdata;
  logic        regulator_en, converter_en, conversion_start, attenuator_on, midscale_on;
  logic [2:0]  channel_sel;
  logic [9:0]  core_result;
  logic [9:0]  level = 10'h000;
  int          errors = 0;
  int          checks_done = 0;

  ads_delay_sequencer #(.BATT_CH(BATT)) ads_delay_sequencer_inst (.clk(clk), .rst(rst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_we(reg_we), .reg_re(reg_re),
    .reg_rdata(reg_rdata), .regulator_en(regulator_en), .converter_en(converter_en),
    .conversion_start(conversion_start), .attenuator_on(attenuator_on),
    .midscale_on(midscale_on), .channel_sel(channel_sel), .core_result(core_result));
  ads_core_model ads_core_model_inst (.clk(clk), .regulator_en(regulator_en),
    .converter_en(converter_en), .midscale_on(midscale_on), .level(level),
    .core_result(core_result));

  // 125 MHz clock
  always #4 clk = ~clk;

  // ************************************************************
  // expectations and bus tasks
  // ************************************************************
  function automatic logic [9:0] exp_res(input logic m, input logic [9:0] v);
    return m ? 10'h200 : v;
  endfunction
  function automatic logic exp_attn(input logic [2:0] ch, input logic a);
    return (ch == BATT) || a;
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED at %0t: %s got %h exp %h", $time, msg, got, exp);
    end
  endtask
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // one write cycle; a gap edge before each strobe keeps drivers single per step
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_we <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_we <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    reg_re <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_re <= 1'b0;
    @(negedge clk);
    d = reg_rdata;
  endtask
  // staggered start, conversion, hold after finish, then counter reset
  task automatic run_seq(input bit keep, input int l, input int e, input int s, input logic m,
                         input logic [9:0] v);
    int t_r, t_e, t_s, w, n;
    logic [31:0] d, d2;
    t_r = -1;
    t_e = -1;
    t_s = -1;
    w = 0;
    level <= v;
    if (!keep) begin
      wr(ads_pkg::OFF_DLY1, (32'(e) << 16) | 32'(l));
      wr(ads_pkg::OFF_DLY2, 32'(s));
    end
    wr(ads_pkg::OFF_AUX, 32'h0000_0001); // counter enable set before start
    wr(ads_pkg::OFF_MAIN, {28'h0000_000, m, 3'b111});
    for (n = 0; n < 6000 && !(t_s >= 0 && !conversion_start); n++) begin
      @(negedge clk);
      if (regulator_en && t_r < 0) t_r = n;
      if (converter_en && t_e < 0) t_e = n;
      if (conversion_start && t_s < 0) t_s = n;
      if (conversion_start) w++;
    end
    if (n == 6000) begin
      errors++;
      $display("CHECK FAILED at %0t: sequence hung", $time);
      give_verdict();
    end
    chk(t_e - t_r, 8 * (e - l), "enable lag");
    chk(t_s - t_e, 8 * (s - e), "start lag");
    chk(32'(w >= 8 && w <= 12), 1, "phase length");
    rd(ads_pkg::OFF_RES, d);
    chk(d, {22'h00_0000, exp_res(m, v)}, "result");
    rd(ads_pkg::OFF_STAT, d);
    chk({d[4:3], d[1:0]}, 4'b1010, "halted and done");
    repeat (40) @(posedge clk);
    rd(ads_pkg::OFF_STAT, d2);
    chk({d2[24:16], d2[4]}, {d[24:16], 1'b1}, "halted count");
    chk({regulator_en, converter_en}, 2'b11, "enables kept");
    // a start written while halted runs a conversion but must not restart the counter
    wr(ads_pkg::OFF_MAIN, {28'h0000_000, m, 3'b111});
    repeat (20) @(posedge clk);
    rd(ads_pkg::OFF_STAT, d2);
    chk({d2[24:16], d2[4:3], d2[1:0]}, {d[24:16], 4'b1010}, "no restart while halted");
    wr(ads_pkg::OFF_AUX, 32'h0000_0000);
    wr(ads_pkg::OFF_STAT, 32'h0000_0002); // write one clears done
    wr(ads_pkg::OFF_MAIN, 32'h0000_0000);
    rd(ads_pkg::OFF_STAT, d);
    chk({d[24:16], d[4:3], d[1]}, 0, "counter and done cleared");
    rd(ads_pkg::OFF_AUX, d);
    chk(d, 0, "enable reads zero");
  endtask

  // ************************************************************
  // main sequence
  // ************************************************************
  initial begin
    logic [31:0] d;
    int l, e, s;
    void'($urandom(88684));
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    rd(ads_pkg::OFF_DLY1, d);
    chk(d, {7'h00, ads_pkg::RST_DLY_EN, 7'h00, ads_pkg::RST_DLY_LDO}, "delay one reset");
    rd(ads_pkg::OFF_DLY2, d);
    chk(d, {23'h00_0000, ads_pkg::RST_DLY_ST}, "delay two reset");
    wr(8'h20, 32'hFFFF_FFFF);
    rd(8'h20, d);
    chk(d, 0, "unmapped read");
    $display("test reset done");
    // counter disabled: outputs follow their bits; enabled but idle: held off
    wr(ads_pkg::OFF_MAIN, 32'h0000_000D);
    repeat (3) @(posedge clk);
    @(negedge clk);
    chk({regulator_en, converter_en, midscale_on, conversion_start}, 4'b1110, "direct");
    wr(ads_pkg::OFF_AUX, 32'h0000_0001);
    repeat (20) @(posedge clk);
    @(negedge clk);
    chk({regulator_en, converter_en}, 2'b00, "gated idle");
    wr(ads_pkg::OFF_AUX, 32'h0000_0000);
    $display("test follow done");
    for (int i = 0; i < 16; i++) begin
      wr(ads_pkg::OFF_AUX, {30'h0000_0000, i[0], 1'b0});
      wr(ads_pkg::OFF_MAIN, {25'h000_0000, i[3:1], 4'h0});
      repeat (125) @(posedge clk); // 1 us settling wait after channel select
      rd(ads_pkg::OFF_STAT, d);
      chk(attenuator_on, exp_attn(i[3:1], i[0]), "attenuator");
      chk(channel_sel, i[3:1], "channel");
      chk({d[5], d[2]}, {exp_attn(i[3:1], i[0]), 1'b1}, "settled status");
    end
    wr(ads_pkg::OFF_AUX, 32'h0000_0000);
    $display("test attenuator done");
    for (int k = 0; k < 6; k++) begin
      l = $urandom % 32;
      e = l + 1 + $urandom % 32;
      s = e + 1 + $urandom % 32;
      if (k == 0) begin
        l = ads_pkg::RST_DLY_LDO;
        e = ads_pkg::RST_DLY_EN;
        s = ads_pkg::RST_DLY_ST;
      end
      if (k == 1) begin
        l = 0;
        e = 1;
        s = 511;
      end
      run_seq(k == 0, l, e, s, 1'($urandom % 2), 10'($urandom));
      $display("test sequence %0d done", k);
    end
    // a reset in mid-run must bring the staggered delays back
    @(posedge clk);
    rst <= 1'b1;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    rd(ads_pkg::OFF_DLY1, d);
    chk(d, {7'h00, ads_pkg::RST_DLY_EN, 7'h00, ads_pkg::RST_DLY_LDO}, "delay one after reset");
    rd(ads_pkg::OFF_DLY2, d);
    chk(d, {23'h00_0000, ads_pkg::RST_DLY_ST}, "delay two after reset");
    $display("test mid-run reset done");
    give_verdict();
  end
endmodule
